/* File: core/drive_start_sequencer.sv */
`timescale 1ns/1ps
module drive_start_sequencer #(
  parameter int unsigned TICK_CYCLES = start_seq_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output start_seq_pkg::drive_cmd_t drive
);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic run;
  logic [15:0] target_freq;
  logic [15:0] start_freq_setting;
  logic [15:0] start_freq_hold_time;
  logic [15:0] prestart_brake_current;
  logic [15:0] prestart_brake_time;
  logic [15:0] lower_limit;
  start_seq_pkg::phase_t phase;
  start_seq_pkg::phase_t next_phase;

  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire [15:0] wdata = pwdata[15:0];
  wire sel_ctrl = (paddr == start_seq_pkg::REG_CTRL);
  wire sel_target = (paddr == start_seq_pkg::REG_TARGET);
  wire sel_start = (paddr == start_seq_pkg::REG_START_FREQ);
  wire sel_hold = (paddr == start_seq_pkg::REG_HOLD_TIME);
  wire sel_bcur = (paddr == start_seq_pkg::REG_BRAKE_CUR);
  wire sel_btime = (paddr == start_seq_pkg::REG_BRAKE_TIME);
  wire sel_lower = (paddr == start_seq_pkg::REG_LOWER_LIMIT);
  wire sel_status = (paddr == start_seq_pkg::REG_STATUS);
  wire sel_out = (paddr == start_seq_pkg::REG_OUT_FREQ);
  wire mapped = sel_ctrl || sel_target || sel_start || sel_hold ||
    sel_bcur || sel_btime || sel_lower || sel_status || sel_out;
  // out-of-range settings are refused and leave the old value
  wire bad_start = sel_start && (wdata > start_seq_pkg::START_FREQ_MAX ||
    pwdata[31:16] != 16'h0000); // [RQ2]
  wire bad_hold = sel_hold && (wdata > start_seq_pkg::HOLD_TIME_MAX ||
    pwdata[31:16] != 16'h0000); // [RQ7]
  wire bad_bcur = sel_bcur && (wdata > start_seq_pkg::BRAKE_CUR_MAX ||
    pwdata[31:16] != 16'h0000); // [RQ11]
  wire bad_btime = sel_btime && (wdata > start_seq_pkg::BRAKE_TIME_MAX ||
    pwdata[31:16] != 16'h0000);
  wire bad_write = pwrite && (bad_start || bad_hold || bad_bcur ||
    bad_btime);
  wire wr_ok = access && pwrite && mapped && !bad_write;

  wire [31:0] status_word = {26'h000_0000,
    phase == start_seq_pkg::PH_BRAKE,
    phase == start_seq_pkg::PH_STANDBY,
    phase == start_seq_pkg::PH_HOLD || phase == start_seq_pkg::PH_RAMP,
    phase};
  wire [31:0] rd_mux =
    sel_ctrl ? {31'h0000_0000, run} :
    sel_target ? {16'h0000, target_freq} :
    sel_start ? {16'h0000, start_freq_setting} :
    sel_hold ? {16'h0000, start_freq_hold_time} :
    sel_bcur ? {16'h0000, prestart_brake_current} :
    sel_btime ? {16'h0000, prestart_brake_time} :
    sel_lower ? {16'h0000, lower_limit} :
    sel_status ? status_word :
    sel_out ? {16'h0000, drive.freq} : 32'h0000_0000;

  // ----------------------------------------
  // apb answer, one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && (!mapped || bad_write);
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // settings registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      target_freq <= start_seq_pkg::TARGET_RST;
      start_freq_setting <= start_seq_pkg::START_FREQ_RST; // [RQ2]
      start_freq_hold_time <= start_seq_pkg::HOLD_TIME_RST; // [RQ7]
      prestart_brake_current <= start_seq_pkg::BRAKE_CUR_RST; // [RQ11]
      prestart_brake_time <= start_seq_pkg::BRAKE_TIME_RST;
      lower_limit <= start_seq_pkg::LOWER_LIMIT_RST;
    end else if (wr_ok) begin
      if (sel_ctrl) run <= pwdata[start_seq_pkg::CTRL_RUN_BIT];
      if (sel_target) target_freq <= wdata;
      if (sel_start) start_freq_setting <= wdata;
      if (sel_hold) start_freq_hold_time <= wdata;
      if (sel_bcur) prestart_brake_current <= wdata;
      if (sel_btime) prestart_brake_time <= wdata;
      if (sel_lower) lower_limit <= wdata;
    end
  end

  // ----------------------------------------
  // snapshot: follows settings while idle
  // ----------------------------------------
  logic [15:0] snap_start;
  logic [15:0] snap_hold;
  logic [15:0] snap_bcur;
  logic [15:0] snap_btime;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_start <= start_seq_pkg::START_FREQ_RST;
      snap_hold <= start_seq_pkg::HOLD_TIME_RST;
      snap_bcur <= start_seq_pkg::BRAKE_CUR_RST;
      snap_btime <= start_seq_pkg::BRAKE_TIME_RST;
    end else if (phase == start_seq_pkg::PH_IDLE) begin // [RQ13]
      snap_start <= start_freq_setting;
      snap_hold <= start_freq_hold_time;
      snap_bcur <= prestart_brake_current;
      snap_btime <= prestart_brake_time;
    end
  end

  // ----------------------------------------
  // tick divider and phase timer
  // ----------------------------------------
  logic [start_seq_pkg::TICK_CNT_W-1:0] div_cnt;
  logic tick;
  logic tmr_load;
  logic tmr_done;
  logic [15:0] tmr_val;

  wire div_wrap =
    (div_cnt == start_seq_pkg::TICK_CNT_W'(TICK_CYCLES - 1));

  // restarted on every timer load so each phase gets whole ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      div_cnt <= (tmr_load || div_wrap) ? '0 : div_cnt + 1'b1; // [RQ13]
      tick <= div_wrap && !tmr_load;
    end
  end

  wire [15:0] hold_ticks =
    16'(snap_hold * start_seq_pkg::HOLD_TICKS_PER_UNIT); // [RQ7]

  assign tmr_load = (next_phase != phase) &&
    (next_phase == start_seq_pkg::PH_BRAKE ||
     next_phase == start_seq_pkg::PH_HOLD);
  assign tmr_val = (next_phase == start_seq_pkg::PH_BRAKE) ?
    snap_btime : hold_ticks;

  phase_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .tick(tick),
    .done(tmr_done)
  );

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  wire below_start = (target_freq < snap_start);
  // lower limit bounds the ramp target only, never the start value
  wire [15:0] ramp_target =
    (target_freq < lower_limit) ? lower_limit : target_freq; // [RQ6]

  always_comb begin
    next_phase = phase;
    case (phase)
      start_seq_pkg::PH_IDLE: begin
        if (run && below_start) begin
          next_phase = start_seq_pkg::PH_STANDBY; // [RQ5]
        end else if (run && snap_btime != start_seq_pkg::FREQ_ZERO) begin
          next_phase = start_seq_pkg::PH_BRAKE; // [RQ8]
        end else if (run) begin
          next_phase = start_seq_pkg::PH_HOLD; // [RQ10]
        end
      end
      start_seq_pkg::PH_BRAKE: begin
        if (tmr_done) next_phase = start_seq_pkg::PH_HOLD; // [RQ9]
      end
      start_seq_pkg::PH_HOLD: begin
        if (tmr_done) next_phase = start_seq_pkg::PH_RAMP; // [RQ4]
      end
      start_seq_pkg::PH_STANDBY: next_phase = start_seq_pkg::PH_STANDBY;
      start_seq_pkg::PH_RAMP: next_phase = start_seq_pkg::PH_RAMP;
      default: next_phase = start_seq_pkg::PH_IDLE;
    endcase
    if (!run) next_phase = start_seq_pkg::PH_IDLE; // [RQ12]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= start_seq_pkg::PH_IDLE;
    end else begin
      phase <= next_phase; // [RQ12]
    end
  end

  // ----------------------------------------
  // drive command output
  // ----------------------------------------
  start_seq_pkg::drive_cmd_t next_drive;
  logic [15:0] ramp_freq;

  always_comb begin
    ramp_freq = drive.freq;
    if (tick && drive.freq < ramp_target) begin
      ramp_freq = drive.freq + start_seq_pkg::RAMP_STEP; // [RQ4]
    end else if (tick && drive.freq > ramp_target) begin
      ramp_freq = drive.freq - start_seq_pkg::RAMP_STEP;
    end
  end

  always_comb begin
    next_drive = '0;
    case (next_phase)
      start_seq_pkg::PH_BRAKE: begin
        next_drive.brake_en = 1'b1; // [RQ8]
        next_drive.brake_level = snap_bcur;
      end
      start_seq_pkg::PH_HOLD: begin
        next_drive.freq = snap_start; // [RQ1] [RQ3] [RQ6]
        next_drive.running = 1'b1;
      end
      start_seq_pkg::PH_RAMP: begin
        next_drive.freq = ramp_freq;
        next_drive.running = 1'b1;
      end
      start_seq_pkg::PH_STANDBY: next_drive.standby = 1'b1; // [RQ5]
      default: next_drive = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] phase_ticks;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ticks <= 16'h0000;
    end else if (next_phase != phase) begin
      phase_ticks <= 16'h0000;
    end else if (tick) begin
      phase_ticks <= phase_ticks + 16'h0001;
    end
  end

  stop_to_idle_a: assert property ( // [RQ12]
    @(posedge pclk) disable iff (!presetn)
    !run |=> phase == start_seq_pkg::PH_IDLE && drive.freq == 16'h0000)
    else $error("stop did not return to idle");

  standby_entry_a: assert property ( // [RQ5]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_IDLE && run && below_start
    |=> phase == start_seq_pkg::PH_STANDBY && drive.standby &&
        !drive.running)
    else $error("low target did not give standby");

  brake_first_a: assert property ( // [RQ8]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_IDLE && run && !below_start &&
    snap_btime != 16'h0000
    |=> drive.brake_en && drive.freq == 16'h0000 &&
        drive.brake_level == $past(snap_bcur))
    else $error("start did not begin with brake");

  skip_brake_a: assert property ( // [RQ10]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_IDLE && run && !below_start &&
    snap_btime == 16'h0000
    |=> phase == start_seq_pkg::PH_HOLD && !drive.brake_en)
    else $error("zero brake time did not skip brake");

  brake_length_a: assert property ( // [RQ9]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_BRAKE &&
    next_phase == start_seq_pkg::PH_HOLD
    |-> phase_ticks == snap_btime)
    else $error("brake phase length wrong");

  hold_length_a: assert property ( // [RQ7]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_HOLD &&
    next_phase == start_seq_pkg::PH_RAMP
    |-> phase_ticks == hold_ticks)
    else $error("hold phase length wrong");

  hold_freq_a: assert property ( // [RQ3]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_HOLD
    |-> drive.freq == snap_start && drive.running)
    else $error("hold output not start frequency");

  no_clamp_a: assert property ( // [RQ6]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_HOLD && snap_start < lower_limit
    |-> drive.freq == snap_start)
    else $error("start frequency was clamped");

  ramp_step_a: assert property ( // [RQ4]
    @(posedge pclk) disable iff (!presetn)
    phase == start_seq_pkg::PH_RAMP && run && tick &&
    drive.freq < ramp_target
    |=> drive.freq == $past(drive.freq) + 16'h0001)
    else $error("ramp did not step up");

  range_guard_a: assert property ( // [RQ2]
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && sel_start &&
    pwdata > {16'h0000, start_seq_pkg::START_FREQ_MAX}
    |=> start_freq_setting == $past(start_freq_setting) &&
        $past(pslverr))
    else $error("out-of-range start frequency taken");

endmodule : drive_start_sequencer

/* File: core/start_seq_pkg.sv */
// Summary of operation
// RQ1: direct start outputs starting frequency first
// RQ2: start frequency 0.00-50.00 Hz, reset 0.50 Hz
// RQ3: hold time keeps output at start frequency
// RQ4: after hold, ramp toward target frequency
// RQ5: target below start frequency gives standby
// RQ6: start frequency not clamped to lower limit
// RQ7: hold time 0.0-50.0 s, reset 0.0 s
// RQ8: start request first applies DC brake current
// RQ9: accelerate only after brake time elapses
// RQ10: zero brake time skips DC braking
// RQ11: brake current in 0.1 percent, reset 0
// RQ12: fixed phase order; stop returns to idle
// RQ13: tick timing; settings apply at next start
package start_seq_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_START_FREQ = 8'h08;
  localparam logic [7:0] REG_HOLD_TIME = 8'h0C;
  localparam logic [7:0] REG_BRAKE_CUR = 8'h10;
  localparam logic [7:0] REG_BRAKE_TIME = 8'h14;
  localparam logic [7:0] REG_LOWER_LIMIT = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_OUT_FREQ = 8'h20;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STAT_RUNNING_BIT = 3;
  localparam int unsigned STAT_STANDBY_BIT = 4;
  localparam int unsigned STAT_BRAKE_BIT = 5;

  // ----------------------------------------
  // reset values and setting limits
  // ----------------------------------------
  localparam logic [15:0] START_FREQ_RST = 16'h0032;
  localparam logic [15:0] START_FREQ_MAX = 16'h1388;
  localparam logic [15:0] HOLD_TIME_RST = 16'h0000;
  localparam logic [15:0] HOLD_TIME_MAX = 16'h01F4;
  localparam logic [15:0] BRAKE_CUR_RST = 16'h0000;
  localparam logic [15:0] BRAKE_CUR_MAX = 16'h03E8;
  localparam logic [15:0] BRAKE_TIME_RST = 16'h0000;
  localparam logic [15:0] BRAKE_TIME_MAX = 16'h1388;
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [15:0] LOWER_LIMIT_RST = 16'h0000;
  localparam logic [15:0] FREQ_ZERO = 16'h0000;
  localparam logic [15:0] RAMP_STEP = 16'h0001;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_PERIOD_MS = 10;
  localparam int unsigned TICK_CYCLES =
    TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 20;
  // hold time unit 0.1 s, tick 10 ms
  localparam logic [15:0] HOLD_TICKS_PER_UNIT = 16'h000A;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_STANDBY,
    PH_BRAKE,
    PH_HOLD,
    PH_RAMP
  } phase_t;

  typedef struct packed {
    logic [15:0] freq;
    logic brake_en;
    logic [15:0] brake_level;
    logic running;
    logic standby;
  } drive_cmd_t;

endpackage : start_seq_pkg

/* File: core/phase_timer.sv */
`timescale 1ns/1ps
module phase_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic tick,
  output logic done
);

  logic [15:0] remain;

  // ----------------------------------------
  // tick down counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= start_seq_pkg::FREQ_ZERO;
    end else if (load) begin
      remain <= load_val;
    end else if (tick && remain != start_seq_pkg::FREQ_ZERO) begin
      remain <= remain - 16'h0001;
    end
  end

  assign done = (remain == start_seq_pkg::FREQ_ZERO);

endmodule : phase_timer

/* File: tb/drive_stage_model.sv */
`timescale 1ns/1ps
// output stage side: tracks brake length and first run frequency
module drive_stage_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire start_seq_pkg::drive_cmd_t drive,
  output int brake_len,
  output logic [15:0] first_freq
);
  logic was_running;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_len <= 0;
      first_freq <= 16'h0000;
      was_running <= 1'b0;
    end else begin
      was_running <= drive.running;
      if (drive.brake_en) begin
        brake_len <= brake_len + 1;
      end else if (drive == '0) begin
        brake_len <= 0;
      end
      if (drive.running && !was_running) begin
        first_freq <= drive.freq;
      end
    end
  end
endmodule : drive_stage_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  start_seq_pkg::drive_cmd_t drive;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 31964;
  int brake_len, n;
  logic [15:0] first_freq, sf, bc;

  drive_start_sequencer #(.TICK_CYCLES(4)) drive_start_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive(drive));

  drive_stage_model drive_stage_model_i (
    .pclk(pclk), .presetn(presetn), .drive(drive),
    .brake_len(brake_len), .first_freq(first_freq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [15:0] ramp_goal(logic [15:0] t, logic [15:0] l);
    return (t > l) ? t : l;
  endfunction : ramp_goal

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      summarize();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
    apb(1'b1, a, {16'h0000, d});
    `CHK(err, e)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e)
  endtask : rd

  task automatic wait_run();
    n = 0;
    while (drive.running !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) begin
      n_fail++;
      summarize();
    end
    #1;
  endtask : wait_run

  task automatic stop();
    wr(start_seq_pkg::REG_CTRL, 16'h0000, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK(drive, start_seq_pkg::drive_cmd_t'('0))
  endtask : stop

  task summarize();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(start_seq_pkg::REG_START_FREQ, 32'h0000_0032);
    rd(start_seq_pkg::REG_HOLD_TIME, 32'h0000_0000);
    rd(start_seq_pkg::REG_BRAKE_CUR, 32'h0000_0000);
    rd(start_seq_pkg::REG_BRAKE_TIME, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    `CHK(err, 1'b1)
    `CHK(rdv, 32'h0000_0000)
    wr(start_seq_pkg::REG_START_FREQ, 16'h1389, 1'b1);
    rd(start_seq_pkg::REG_START_FREQ, 32'h0000_0032);
    wr(start_seq_pkg::REG_START_FREQ, 16'h1388, 1'b0);
    wr(start_seq_pkg::REG_HOLD_TIME, 16'h01F5, 1'b1);
    wr(start_seq_pkg::REG_HOLD_TIME, 16'h01F4, 1'b0);
    rd(start_seq_pkg::REG_HOLD_TIME, 32'h0000_01F4);
    wr(start_seq_pkg::REG_BRAKE_CUR, 16'h03E9, 1'b1);
    wr(start_seq_pkg::REG_BRAKE_CUR, 16'h03E8, 1'b0);
    // direct start, start frequency below the lower limit
    sf = 16'h0064 + (16'($random(seed)) & 16'h00FF);
    wr(start_seq_pkg::REG_START_FREQ, sf, 1'b0);
    wr(start_seq_pkg::REG_HOLD_TIME, 16'h0000, 1'b0);
    wr(start_seq_pkg::REG_LOWER_LIMIT, sf + 16'h0002, 1'b0);
    wr(start_seq_pkg::REG_TARGET, sf + 16'h0005, 1'b0);
    wr(start_seq_pkg::REG_CTRL, 16'h0001, 1'b0);
    wait_run();
    `CHK(first_freq, sf)
    `CHK(brake_len, 0)
    repeat (100) @(posedge pclk);
    `CHK(drive.freq, ramp_goal(sf + 16'h0005, sf + 16'h0002))
    stop();
    // brake, then hold, then ramp
    bc = 16'($random(seed)) & 16'h01FF;
    wr(start_seq_pkg::REG_BRAKE_CUR, bc, 1'b0);
    wr(start_seq_pkg::REG_BRAKE_TIME, 16'h0003, 1'b0);
    wr(start_seq_pkg::REG_HOLD_TIME, 16'h0001, 1'b0);
    wr(start_seq_pkg::REG_LOWER_LIMIT, 16'h0000, 1'b0);
    wr(start_seq_pkg::REG_TARGET, sf + 16'h0014, 1'b0);
    wr(start_seq_pkg::REG_CTRL, 16'h0001, 1'b0);
    n = 0;
    while (drive.brake_en !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
    #1;
    `CHK(drive.brake_level, bc)
    `CHK(drive.running, 1'b0)
    rd(start_seq_pkg::REG_STATUS, 32'h0000_0022);
    wait_run();
    `CHK(brake_len >= 12 && brake_len <= 14, 1'b1)
    wr(start_seq_pkg::REG_START_FREQ, sf + 16'h0032, 1'b0);
    repeat (28) begin
      @(posedge pclk);
      `CHK(drive.freq, sf)
    end
    rd(start_seq_pkg::REG_OUT_FREQ, {16'h0000, sf});
    repeat (60) @(posedge pclk);
    `CHK(drive.freq > sf, 1'b1)
    stop();
    // target below the start frequency
    wr(start_seq_pkg::REG_BRAKE_TIME, 16'h0000, 1'b0);
    wr(start_seq_pkg::REG_TARGET, sf + 16'h0031, 1'b0);
    wr(start_seq_pkg::REG_CTRL, 16'h0001, 1'b0);
    repeat (20) @(posedge pclk);
    `CHK(drive.standby, 1'b1)
    `CHK(drive.running, 1'b0)
    stop();
    // setting written during the earlier run applies at the next start
    wr(start_seq_pkg::REG_TARGET, sf + 16'h003C, 1'b0);
    wr(start_seq_pkg::REG_CTRL, 16'h0001, 1'b0);
    wait_run();
    `CHK(first_freq, sf + 16'h0032)
    stop();
    summarize();
  end
endmodule : tb
